// *** rtl/bpg_burst_pulse_generator.v ***
// Summary of operation
// (R1) A 3-bit mode field selects how both low-side gate outputs are driven.
// (R2) Mode 000: push-pull pair started by trigger A, timed by A spans and gap.
// (R3) The gap between push-pull outputs is an 8-bit count of 16 MHz ticks.
// (R4) Mode 001: output A from generator A, output B follows port bit one.
// (R5) Generator A issues exactly the channel-A pulse count per burst, 0 to 63.
// (R6) Generator A times pulses by 11-bit high and low spans in 16 MHz ticks.
// (R7) Mode 010: output A follows port bit zero, output B from generator B.
// (R8) Generator B issues exactly the channel-B pulse count per burst, 0 to 63.
// (R9) Generator B times pulses by its own 11-bit spans in 16 MHz ticks.
// (R10) Writing 1 to trigger bit A starts a burst on generator A; the code passes it only in modes 000, 001 and 011.
// (R11) Writing 1 to trigger bit B starts a burst on generator B; the code passes it only in modes 010 and 011.
// (R12) Mode 011: generators A and B run independently onto outputs A and B.
// (R13) Mode 100: both outputs come straight from the port pins.
// (R14) In port drive, A follows port bit zero and B follows port bit one.
// (R15) Software must not program mode 101.
// (R16) Software must not program modes 110 or 111.
// (R17) Pulse is high span active, low span inactive, repeated count times; zero gives none.
// (R18) Push-pull outputs alternate, never overlap, both idle for the gap between.
//
// The implementer's own choices: the register offsets and register access over Wishbone.

`include "bpg_defs.vh"

////////////////////////////////////////////////////////////////////////////////
module bpg_generator #(
	parameter SPAN_W  = `BPG_SPAN_W,
	parameter COUNT_W = `BPG_COUNT_W,
	parameter GAP_W   = `BPG_GAP_W
) (
	input  wire               clk_sys,
	input  wire               rst,
	input  wire               tick,
	input  wire               start,
	input  wire               push_pull,
	input  wire [COUNT_W-1:0] pulse_count,
	input  wire [SPAN_W-1:0]  high_span,
	input  wire [SPAN_W-1:0]  low_span,
	input  wire [GAP_W-1:0]   gap_span,
	output wire               drive_high,
	output wire               drive_low,
	output wire               busy
);
	localparam [2:0] ST_IDLE = 3'h0;
	localparam [2:0] ST_HIGH = 3'h1;
	localparam [2:0] ST_GAP1 = 3'h2;
	localparam [2:0] ST_LOW  = 3'h3;
	localparam [2:0] ST_GAP2 = 3'h4;
	reg [2:0]         state;
	reg [SPAN_W-1:0]  span_cnt;
	reg [COUNT_W-1:0] pulses_left;
	// A span of zero still lasts one tick, so phases never vanish
	function span_done;
		input [SPAN_W-1:0] cnt;
		input [SPAN_W-1:0] limit;
		begin
			span_done = ({1'b0, cnt} + {{SPAN_W{1'b0}}, 1'b1}) >= {1'b0, limit};
		end
	endfunction

	wire [SPAN_W-1:0] gap_wide = {{(SPAN_W-GAP_W){1'b0}}, gap_span};
	wire              last     = (pulses_left == {{(COUNT_W-1){1'b0}}, 1'b1});
	assign drive_high = (state == ST_HIGH);
	assign drive_low  = (state == ST_LOW);
	assign busy       = (state != ST_IDLE);
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state       <= ST_IDLE;
			span_cnt    <= `BPG_RST_SPAN;
			pulses_left <= `BPG_RST_COUNT;
		end else begin
			case (state)
			ST_IDLE: begin
				span_cnt <= `BPG_RST_SPAN;
				if (start && pulse_count != {COUNT_W{1'b0}}) begin // R17
					state       <= ST_HIGH;
					pulses_left <= pulse_count; // R5 R8
				end
			end
			ST_HIGH: begin
				if (tick) begin
					if (span_done(span_cnt, high_span)) begin // R6 R9
						span_cnt <= `BPG_RST_SPAN;
						state    <= push_pull ? ST_GAP1 : ST_LOW; // R18
					end else begin
						span_cnt <= span_cnt + {{(SPAN_W-1){1'b0}}, 1'b1};
					end
				end
			end
			ST_GAP1: begin
				if (tick) begin
					if (span_done(span_cnt, gap_wide)) begin // R3 R18
						span_cnt <= `BPG_RST_SPAN;
						state    <= ST_LOW;
					end else begin
						span_cnt <= span_cnt + {{(SPAN_W-1){1'b0}}, 1'b1};
					end
				end
			end
			ST_LOW: begin
				if (tick) begin
					if (span_done(span_cnt, low_span)) begin // R6 R9
						span_cnt <= `BPG_RST_SPAN;
						if (push_pull) begin
							state <= ST_GAP2; // R18
						end else if (last) begin
							state <= ST_IDLE; // R17
						end else begin
							state       <= ST_HIGH;
							pulses_left <= pulses_left - {{(COUNT_W-1){1'b0}}, 1'b1};
						end
					end else begin
						span_cnt <= span_cnt + {{(SPAN_W-1){1'b0}}, 1'b1};
					end
				end
			end
			ST_GAP2: begin
				if (tick) begin
					if (span_done(span_cnt, gap_wide)) begin // R3 R18
						span_cnt <= `BPG_RST_SPAN;
						if (last) begin
							state <= ST_IDLE;
						end else begin
							state       <= ST_HIGH;
							pulses_left <= pulses_left - {{(COUNT_W-1){1'b0}}, 1'b1};
						end
					end else begin
						span_cnt <= span_cnt + {{(SPAN_W-1){1'b0}}, 1'b1};
					end
				end
			end
			default: begin
				state <= ST_IDLE;
			end
			endcase
		end
	end
endmodule // bpg_generator

////////////////////////////////////////////////////////////////////////////////
module bpg_burst_pulse_generator #(
	parameter SPAN_W  = `BPG_SPAN_W,
	parameter COUNT_W = `BPG_COUNT_W,
	parameter GAP_W   = `BPG_GAP_W
) (
	input  wire        clk_sys,
	input  wire        rst,
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [31:0] wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output reg  [31:0] wb_dat_o,
	output reg         wb_ack_o,
	input  wire        port_two_bit_zero,
	input  wire        port_two_bit_one,
	output reg         gate_drive_a,
	output reg         gate_drive_b
);
	reg [`BPG_MODE_W-1:0] mode;
	reg [COUNT_W-1:0]     count_a;
	reg [COUNT_W-1:0]     count_b;
	reg [SPAN_W-1:0]      high_span_a;
	reg [SPAN_W-1:0]      low_span_a;
	reg [SPAN_W-1:0]      high_span_b;
	reg [SPAN_W-1:0]      low_span_b;
	reg [GAP_W-1:0]       gap_span;
	reg                   start_a;
	reg                   start_b;
	reg [`BPG_ACC_W-1:0]  tick_acc;
	reg                   tick;
	reg                   next_a;
	reg                   next_b;

	wire gen_a_high;
	wire gen_a_low;
	wire gen_a_busy;
	wire gen_b_high;
	wire gen_b_low;
	wire gen_b_busy;
	wire                  req      = wb_cyc_i & wb_stb_i;
	wire                  wr_now   = req & wb_we_i & wb_ack_o;
	wire [`BPG_ADDR_W-1:0] adr     = wb_adr_i[`BPG_ADDR_W-1:0];
	wire                  adr_high = (wb_adr_i[31:`BPG_ADDR_W] != {(32-`BPG_ADDR_W){1'b0}});
	wire                  push_pull = (mode == `BPG_MODE_PUSH_PULL);
	// Byte-lane merge; spans never reach past the two low lanes
	function [SPAN_W-1:0] merge;
		input [SPAN_W-1:0] old;
		input [15:0]       din;
		input [1:0]        sel;
		reg   [15:0]       full;
		begin
			full       = {{(16-SPAN_W){1'b0}}, old};
			full[7:0]  = sel[0] ? din[7:0]  : full[7:0];
			full[15:8] = sel[1] ? din[15:8] : full[15:8];
			merge      = full[SPAN_W-1:0];
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// 16 MHz span tick from 25 MHz: fractional accumulator, jitter one cycle
	wire [`BPG_ACC_W:0] acc_sum  = {1'b0, tick_acc} + `BPG_SPAN_MHZ;
	wire [`BPG_ACC_W:0] acc_wrap = acc_sum - `BPG_SYS_MHZ;
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			tick_acc <= {`BPG_ACC_W{1'b0}};
			tick     <= 1'b0;
		end else if (acc_sum >= `BPG_SYS_MHZ) begin
			tick_acc <= acc_wrap[`BPG_ACC_W-1:0]; // R6 R9
			tick     <= 1'b1;
		end else begin
			tick_acc <= acc_sum[`BPG_ACC_W-1:0];
			tick     <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Wishbone slave: ack one cycle after request, write on the ack edge
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			wb_ack_o    <= 1'b0;
			wb_dat_o    <= 32'h00000000;
			mode        <= `BPG_RST_MODE;
			count_a     <= `BPG_RST_COUNT;
			count_b     <= `BPG_RST_COUNT;
			high_span_a <= `BPG_RST_SPAN;
			low_span_a  <= `BPG_RST_SPAN;
			high_span_b <= `BPG_RST_SPAN;
			low_span_b  <= `BPG_RST_SPAN;
			gap_span    <= `BPG_RST_GAP;
			start_a     <= 1'b0;
			start_b     <= 1'b0;
		end else begin
			wb_ack_o <= req & ~wb_ack_o;
			start_a  <= 1'b0;
			start_b  <= 1'b0;
			if (req & ~wb_ack_o) begin
				wb_dat_o <= 32'h00000000;
				if (adr_high) begin
					wb_dat_o <= 32'h00000000;
				end else if (adr == `BPG_OFS_MODE) begin
					wb_dat_o[`BPG_MODE_W-1:0] <= mode;
				end else if (adr == `BPG_OFS_ENABLE) begin
					// Trigger bits read back as generator busy
					wb_dat_o[`BPG_TRIG_A_BIT] <= gen_a_busy;
					wb_dat_o[`BPG_TRIG_B_BIT] <= gen_b_busy;
				end else if (adr == `BPG_OFS_COUNT_A) begin
					wb_dat_o[COUNT_W-1:0] <= count_a;
				end else if (adr == `BPG_OFS_COUNT_B) begin
					wb_dat_o[COUNT_W-1:0] <= count_b;
				end else if (adr == `BPG_OFS_HIGH_A) begin
					wb_dat_o[SPAN_W-1:0] <= high_span_a;
				end else if (adr == `BPG_OFS_LOW_A) begin
					wb_dat_o[SPAN_W-1:0] <= low_span_a;
				end else if (adr == `BPG_OFS_HIGH_B) begin
					wb_dat_o[SPAN_W-1:0] <= high_span_b;
				end else if (adr == `BPG_OFS_LOW_B) begin
					wb_dat_o[SPAN_W-1:0] <= low_span_b;
				end else if (adr == `BPG_OFS_GAP) begin
					wb_dat_o[GAP_W-1:0] <= gap_span;
				end
			end
			if (wr_now && !adr_high) begin
				if (adr == `BPG_OFS_MODE && wb_sel_i[0]) begin
					mode <= wb_dat_i[`BPG_MODE_W-1:0]; // R1
				end else if (adr == `BPG_OFS_ENABLE && wb_sel_i[0]) begin
					// Triggers only reach generators that own an output
					start_a <= wb_dat_i[`BPG_TRIG_A_BIT] && (push_pull || mode == `BPG_MODE_GEN_A ||
						mode == `BPG_MODE_GEN_AB); // R10 R2
					start_b <= wb_dat_i[`BPG_TRIG_B_BIT] && (mode == `BPG_MODE_GEN_B ||
						mode == `BPG_MODE_GEN_AB); // R11
				end else if (adr == `BPG_OFS_COUNT_A && wb_sel_i[0]) begin
					count_a <= wb_dat_i[COUNT_W-1:0];
				end else if (adr == `BPG_OFS_COUNT_B && wb_sel_i[0]) begin
					count_b <= wb_dat_i[COUNT_W-1:0];
				end else if (adr == `BPG_OFS_HIGH_A) begin
					high_span_a <= merge(high_span_a, wb_dat_i[15:0], wb_sel_i[1:0]);
				end else if (adr == `BPG_OFS_LOW_A) begin
					low_span_a <= merge(low_span_a, wb_dat_i[15:0], wb_sel_i[1:0]);
				end else if (adr == `BPG_OFS_HIGH_B) begin
					high_span_b <= merge(high_span_b, wb_dat_i[15:0], wb_sel_i[1:0]);
				end else if (adr == `BPG_OFS_LOW_B) begin
					low_span_b <= merge(low_span_b, wb_dat_i[15:0], wb_sel_i[1:0]);
				end else if (adr == `BPG_OFS_GAP && wb_sel_i[0]) begin
					gap_span <= wb_dat_i[GAP_W-1:0]; // R3
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	bpg_generator #(
		.SPAN_W  (SPAN_W),
		.COUNT_W (COUNT_W),
		.GAP_W   (GAP_W)
	) u_gen_a (
		.clk_sys     (clk_sys),
		.rst         (rst),
		.tick        (tick),
		.start       (start_a),
		.push_pull   (push_pull),
		.pulse_count (count_a),
		.high_span   (high_span_a),
		.low_span    (low_span_a),
		.gap_span    (gap_span),
		.drive_high  (gen_a_high),
		.drive_low   (gen_a_low),
		.busy        (gen_a_busy)
	);
	bpg_generator #(
		.SPAN_W  (SPAN_W),
		.COUNT_W (COUNT_W),
		.GAP_W   (GAP_W)
	) u_gen_b (
		.clk_sys     (clk_sys),
		.rst         (rst),
		.tick        (tick),
		.start       (start_b),
		.push_pull   (1'b0),
		.pulse_count (count_b),
		.high_span   (high_span_b),
		.low_span    (low_span_b),
		.gap_span    (gap_span),
		.drive_high  (gen_b_high),
		.drive_low   (),
		.busy        (gen_b_busy)
	);

	////////////////////////////////////////////////////////////////////////
	// Output select; undefined modes park both switches off
	always @* begin
		next_a = 1'b0;
		next_b = 1'b0;
		case (mode)
		`BPG_MODE_PUSH_PULL: begin
			next_a = gen_a_high; // R2 R18
			next_b = gen_a_low;
		end
		`BPG_MODE_GEN_A: begin
			next_a = gen_a_high; // R4
			next_b = port_two_bit_one;
		end
		`BPG_MODE_GEN_B: begin
			next_a = port_two_bit_zero; // R7
			next_b = gen_b_high;
		end
		`BPG_MODE_GEN_AB: begin
			next_a = gen_a_high; // R12
			next_b = gen_b_high;
		end
		`BPG_MODE_PORT: begin
			next_a = port_two_bit_zero; // R13 R14
			next_b = port_two_bit_one;
		end
		default: begin
			next_a = 1'b0; // R15 R16
			next_b = 1'b0;
		end
		endcase
	end
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			gate_drive_a <= 1'b0;
			gate_drive_b <= 1'b0;
		end else begin
			gate_drive_a <= next_a;
			gate_drive_b <= next_b;
		end
	end
endmodule // bpg_burst_pulse_generator

// *** rtl/bpg_defs.vh ***
`ifndef BPG_DEFS_VH
`define BPG_DEFS_VH

// Register byte offsets
`define BPG_ADDR_W        6
`define BPG_OFS_MODE      6'h00
`define BPG_OFS_ENABLE    6'h04
`define BPG_OFS_COUNT_A   6'h08
`define BPG_OFS_COUNT_B   6'h0C
`define BPG_OFS_HIGH_A    6'h10
`define BPG_OFS_LOW_A     6'h14
`define BPG_OFS_HIGH_B    6'h18
`define BPG_OFS_LOW_B     6'h1C
`define BPG_OFS_GAP       6'h20

// Field widths and positions
`define BPG_MODE_W        3
`define BPG_COUNT_W       6
`define BPG_SPAN_W        11
`define BPG_GAP_W         8
`define BPG_TRIG_A_BIT    0
`define BPG_TRIG_B_BIT    1

// Mode field encodings
`define BPG_MODE_PUSH_PULL 3'h0
`define BPG_MODE_GEN_A     3'h1
`define BPG_MODE_GEN_B     3'h2
`define BPG_MODE_GEN_AB    3'h3
`define BPG_MODE_PORT      3'h4

// Reset values
`define BPG_RST_MODE      3'h4
`define BPG_RST_COUNT     6'h00
`define BPG_RST_SPAN      11'h000
`define BPG_RST_GAP       8'h00

// Span time base: 16 MHz ticks made from the 25 MHz clock
`define BPG_SYS_MHZ       6'h19
`define BPG_SPAN_MHZ      6'h10
`define BPG_ACC_W         5

`endif

// *** verification/bpg_burst_pulse_generator_test.sv ***
`include "bpg_defs.vh"
module bpg_burst_pulse_generator_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_sys, rst, cyc, stb, we, p0, p1, clr, ack, ga, gb, ovl;
	logic [31:0] adr, wdat, rdat, q;
	logic [3:0]  sel;
	logic [15:0] ra, rb, ha, hb;
	int          bad_count, checks;
	bpg_burst_pulse_generator dut (.clk_sys(clk_sys), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.port_two_bit_zero(p0), .port_two_bit_one(p1), .gate_drive_a(ga), .gate_drive_b(gb));
	bpg_gate_load load (.clk_sys(clk_sys), .clr(clr), .gate_drive_a(ga), .gate_drive_b(gb),
		.rises_a(ra), .rises_b(rb), .high_a(ha), .high_b(hb), .overlap(ovl));
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	////////////////////////////////////////////////////////////
	task automatic tally_and_finish;
		$display("checks=%0d bad_count=%0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic near(input logic [15:0] got, input int exp, input int tol);
		chk(32'((int'(got) >= exp - tol) && (int'(got) <= exp + tol)), 32'h1);
	endtask
	task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d);
		int n;
		n = 0;
		cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
		// Ack is seen at the rising edge, before the slave's own update lands
		do begin
			@(posedge clk_sys);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (ack !== 1'b1) begin
			bad_count++;
			tally_and_finish();
		end
		q = rdat;
		cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d); wb(1'b1, a, d); endtask
	task automatic rd(input logic [31:0] a); wb(1'b0, a, 32'h0); endtask
	// Clears the load counters, triggers, then polls busy until both idle
	task automatic fire(input logic [31:0] t);
		int n;
		clr <= 1'b1;
		@(posedge clk_sys);
		clr <= 1'b0;
		wr(`BPG_OFS_ENABLE, t);
		n = 0;
		do begin
			rd(`BPG_OFS_ENABLE);
			n++;
		end while (q[1:0] !== 2'h0 && n < 2000);
		if (n >= 2000) begin
			bad_count++;
			tally_and_finish();
		end
		repeat (4) @(posedge clk_sys);
	endtask
	////////////////////////////////////////////////////////////
	task automatic t_regs;
		rd(`BPG_OFS_MODE); chk(q, 32'h4);
		rd(`BPG_OFS_HIGH_A); chk(q, 32'h0);
		wr(`BPG_OFS_COUNT_A, 32'hFF); rd(`BPG_OFS_COUNT_A); chk(q, 32'h3F);
		wr(`BPG_OFS_GAP, 32'h1FF); rd(`BPG_OFS_GAP); chk(q, 32'hFF);
		wr(32'h40, 32'h5); rd(32'h40); chk(q, 32'h0);
	endtask
	task automatic t_port;
		for (int i = 0; i < 4; i++) begin
			p0 <= i[0]; p1 <= i[1];
			repeat (3) @(posedge clk_sys);
			chk({30'h0, ga, gb}, {30'h0, i[0], i[1]});
		end
		for (int m = 5; m < 8; m++) begin
			wr(`BPG_OFS_MODE, 32'(m));
			repeat (3) @(posedge clk_sys);
			chk({30'h0, ga, gb}, 32'h0);
		end
	endtask
	task automatic t_gen_a;
		wr(`BPG_OFS_MODE, 32'h1); wr(`BPG_OFS_COUNT_A, 32'h3F);
		wr(`BPG_OFS_HIGH_A, 32'h5); wr(`BPG_OFS_LOW_A, 32'h3);
		fire(32'h1);
		chk(32'(ra), 32'h3F);
		near(ha, 63 * 5 * 25 / 16, 65);
		chk(32'(gb), 32'h1);
	endtask
	task automatic t_gen_b;
		wr(`BPG_OFS_MODE, 32'h2); wr(`BPG_OFS_COUNT_B, 32'h4);
		wr(`BPG_OFS_HIGH_B, 32'h9); wr(`BPG_OFS_LOW_B, 32'h2);
		p0 <= 1'b0;
		fire(32'h2);
		chk(32'(rb), 32'h4);
		near(hb, 4 * 9 * 25 / 16, 6);
		chk(32'(ra), 32'h0);
	endtask
	task automatic t_indep;
		wr(`BPG_OFS_MODE, 32'h3); wr(`BPG_OFS_COUNT_A, 32'h3); wr(`BPG_OFS_HIGH_A, 32'h2);
		wr(`BPG_OFS_COUNT_B, 32'h5); wr(`BPG_OFS_HIGH_B, 32'h6);
		fire(32'h3);
		chk(32'(ra), 32'h3);
		chk(32'(rb), 32'h5);
		near(hb, 5 * 6 * 25 / 16, 7);
		wr(`BPG_OFS_COUNT_A, 32'h0);
		fire(32'h1);
		chk(32'(ra), 32'h0);
	endtask
	task automatic t_push;
		wr(`BPG_OFS_MODE, 32'h0); wr(`BPG_OFS_COUNT_A, 32'h2); wr(`BPG_OFS_HIGH_A, 32'h4);
		wr(`BPG_OFS_LOW_A, 32'h7); wr(`BPG_OFS_GAP, 32'h3);
		fire(32'h1);
		chk(32'(ra), 32'h2);
		chk(32'(rb), 32'h2);
		chk(32'(ovl), 32'h0);
		near(ha, 2 * 4 * 25 / 16, 4);
		near(hb, 2 * 7 * 25 / 16, 4);
	endtask
	////////////////////////////////////////////////////////////
	initial begin
		bad_count = 0;
		checks = 0;
		rst = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 32'h0; wdat = 32'h0;
		sel = 4'hF; p0 = 1'b0; p1 = 1'b0; clr = 1'b1;
		repeat (10) @(posedge clk_sys);
		rst <= 1'b0;
		clr <= 1'b0;
		@(posedge clk_sys);
		t_regs();
		t_port();
		p1 <= 1'b1;
		t_gen_a();
		t_gen_b();
		t_indep();
		t_push();
		tally_and_finish();
	end
endmodule // bpg_burst_pulse_generator_test
bind bpg_burst_pulse_generator bpg_props chk_i (.clk_sys(clk_sys), .rst(rst), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .port_two_bit_zero(port_two_bit_zero),
	.port_two_bit_one(port_two_bit_one), .gate_drive_a(gate_drive_a), .gate_drive_b(gate_drive_b));

// *** verification/bpg_gate_load.sv ***
module bpg_gate_load (
	input  wire logic        clk_sys,
	input  wire logic        clr,
	input  wire logic        gate_drive_a,
	input  wire logic        gate_drive_b,
	output logic      [15:0] rises_a,
	output logic      [15:0] rises_b,
	output logic      [15:0] high_a,
	output logic      [15:0] high_b,
	output logic             overlap
);
	timeunit 1ns;
	timeprecision 1ps;
	logic pa;
	logic pb;
	// Load only counts edges and on-time and flags overlap; a switch never answers back
	always @(posedge clk_sys) begin
		pa <= gate_drive_a;
		pb <= gate_drive_b;
		if (clr) begin
			rises_a <= 16'h0000;
			rises_b <= 16'h0000;
			high_a  <= 16'h0000;
			high_b  <= 16'h0000;
			overlap <= 1'b0;
		end else begin
			if (gate_drive_a && !pa) rises_a <= rises_a + 16'h0001;
			if (gate_drive_b && !pb) rises_b <= rises_b + 16'h0001;
			if (gate_drive_a) high_a <= high_a + 16'h0001;
			if (gate_drive_b) high_b <= high_b + 16'h0001;
			// Both switches on at once shorts the primary
			if (gate_drive_a && gate_drive_b) overlap <= 1'b1;
		end
	end
endmodule // bpg_gate_load

// *** verification/bpg_props.sv ***
`include "bpg_defs.vh"
module bpg_props (
	input wire logic        clk_sys,
	input wire logic        rst,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [31:0] wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        port_two_bit_zero,
	input wire logic        port_two_bit_one,
	input wire logic        gate_drive_a,
	input wire logic        gate_drive_b
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] mode_q;
	logic [5:0] cnt_a;
	wire wr_hit = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_adr_i[31:6] == 26'h0 && wb_sel_i[0];
	// Shadow of mode and count, since the checker sees only ports
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			mode_q <= 3'h4;
			cnt_a  <= 6'h00;
		end else if (wr_hit && wb_adr_i[5:0] == `BPG_OFS_MODE) begin
			mode_q <= wb_dat_i[2:0];
		end else if (wr_hit && wb_adr_i[5:0] == `BPG_OFS_COUNT_A) begin
			cnt_a <= wb_dat_i[5:0];
		end
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	// Only valid while generator A is idle at trigger time
	sequence trig_a;
		wr_hit && wb_adr_i[5:0] == `BPG_OFS_ENABLE && wb_dat_i[0] && mode_q == 3'h3 && !gate_drive_a;
	endsequence
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_ack_answers: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack missing");
	a_port_a_follow: assert property (mode_q == 3'h4 |=> gate_drive_a == $past(port_two_bit_zero))
		else $error("gate a not following pin");
	a_port_b_follow: assert property (mode_q == 3'h4 |=> gate_drive_b == $past(port_two_bit_one))
		else $error("gate b not following pin");
	a_mode_one_pin: assert property (mode_q == 3'h1 |=> gate_drive_b == $past(port_two_bit_one))
		else $error("gate b not following pin");
	a_mode_two_pin: assert property (mode_q == 3'h2 |=> gate_drive_a == $past(port_two_bit_zero))
		else $error("gate a not following pin");
	a_push_no_overlap: assert property (mode_q == 3'h0 |-> !(gate_drive_a && gate_drive_b))
		else $error("push pull overlap");
	a_reserved_quiet: assert property (mode_q >= 3'h5 |=> !gate_drive_a && !gate_drive_b)
		else $error("reserved mode drives gates");
	a_trigger_starts: assert property (trig_a and cnt_a != 6'h00 |-> ##3 gate_drive_a)
		else $error("burst a did not start");
	a_zero_count: assert property (trig_a and cnt_a == 6'h00 |=> !gate_drive_a [*8])
		else $error("pulse with zero count");
endmodule // bpg_props
